// [dls_defines.vh]
`ifndef DLS_DEFINES_VH
`define DLS_DEFINES_VH

// ----------------------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------------------
// System clock rate in MHz and microseconds in one second.
`define DLS_CLK_MHZ       250
`define DLS_US_PER_S      1000000
// Polling direction is swapped after this many seconds (60).
`define DLS_DIR_SWAP_S    10'h03c
// Retry interval in minutes (10) and the same interval in seconds.
`define DLS_RETRY_MIN     10'h00a
`define DLS_SEC_PER_MIN   10'h03c
`define DLS_RETRY_S       (`DLS_RETRY_MIN * `DLS_SEC_PER_MIN)

// ----------------------------------------------------------------------------
// Loop geometry
// ----------------------------------------------------------------------------
// Highest unit address on one loop (99 units).
`define DLS_MAX_UNITS     7'h63
// Lowest unit address polled in a round.
`define DLS_FIRST_UNIT    7'h01

// ----------------------------------------------------------------------------
// Address jumpers
// ----------------------------------------------------------------------------
// Bit positions of the jumpers inside the board number.
`define DLS_JMP_BIT0      0
`define DLS_JMP_BIT1      1
`define DLS_JMP_BIT2      2
// This board type leaves the third jumper out of the board number.
`define DLS_USE_JUMPER2   1'b0
// Board number held until the jumpers have been sampled.
`define DLS_BOARD_RST     3'h0

// ----------------------------------------------------------------------------
// Fault kinds reported on the fault port
// ----------------------------------------------------------------------------
`define DLS_FK_NONE       2'h0
`define DLS_FK_CUTOFF     2'h1
`define DLS_FK_SHORT      2'h2
`define DLS_FK_NOREPLY    2'h3

`endif

// [dls_loop_ctrl.v]
`timescale 1ns/100ps
`default_nettype none

`include "dls_defines.vh"

// Supervision of one detector loop: polling rounds, break and short handling.
module dls_loop_ctrl
(
  input  wire       clk_sys,
  input  wire       reset_n,
  input  wire       clk_en,
  input  wire       dir_tick,
  input  wire       retry_tick,
  input  wire       short_seen,
  input  wire [6:0] unit_limit,
  input  wire       answer_ok,
  input  wire       answer_none,
  input  wire       nr_taken,
  output reg        poll_req,
  output reg  [6:0] poll_unit,
  output reg        drive_a,
  output reg        drive_b,
  output reg        dual,
  output reg        cutoff,
  output reg        shorted,
  output reg        nr_valid,
  output reg  [6:0] nr_unit
);

  localparam [2:0] S_START = 3'h0;
  localparam [2:0] S_POLL  = 3'h1;
  localparam [2:0] S_WAIT  = 3'h2;
  localparam [2:0] S_HOLD  = 3'h3;
  localparam [2:0] S_NEXT  = 3'h4;
  localparam [2:0] S_END   = 3'h5;
  localparam [2:0] S_OFF   = 3'h6;

  reg [2:0] state;
  reg [6:0] unit;
  reg       dir;
  reg       any_silent;
  reg       reported;
  reg       retry_pend;

  // --------------------------------------------------------------------------
  // Round sequencer
  // --------------------------------------------------------------------------
  // A short overrides every state but S_OFF; a pending no-reply stays until taken.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state      <= S_START;
      unit       <= `DLS_FIRST_UNIT;
      dir        <= 1'b0;
      any_silent <= 1'b0;
      reported   <= 1'b0;
      retry_pend <= 1'b0;
      poll_req   <= 1'b0;
      poll_unit  <= `DLS_FIRST_UNIT;
      drive_a    <= 1'b0;
      drive_b    <= 1'b0;
      dual       <= 1'b0;
      cutoff     <= 1'b0;
      shorted    <= 1'b0;
      nr_valid   <= 1'b0;
      nr_unit    <= 7'h00;
    end
    else if (clk_en)
    begin
      poll_req <= 1'b0;
      if (nr_valid && nr_taken)
        nr_valid <= 1'b0;
      if (dir_tick)
        dir <= ~dir;                                   // [R5]
      if (retry_tick && dual)
        retry_pend <= 1'b1;
      if (short_seen && state != S_OFF)
      begin
        state   <= S_OFF;                              // [R11]
        drive_a <= 1'b0;
        drive_b <= 1'b0;
        shorted <= 1'b1;
      end
      else
      begin
        case (state)
          S_START:
          begin
            // One end drives in normal rounds, both ends after a break.
            unit       <= `DLS_FIRST_UNIT;
            any_silent <= 1'b0;
            drive_a    <= dual | ~dir;                 // [R5] [R7]
            drive_b    <= dual | dir;
            if (unit_limit != 7'h00)
              state <= S_POLL;
          end
          S_POLL:
          begin
            poll_req  <= 1'b1;                         // [R4]
            poll_unit <= unit;
            state     <= S_WAIT;
          end
          S_WAIT:
          begin
            if (answer_none)
            begin
              any_silent <= 1'b1;                      // [R14]
              if (dual && !reported)
              begin
                nr_valid <= 1'b1;                      // [R9]
                nr_unit  <= unit;
                state    <= S_HOLD;
              end
              else
                state <= S_NEXT;
            end
            else if (answer_ok)
              state <= S_NEXT;
          end
          S_HOLD:
          begin
            if (!nr_valid)
              state <= S_NEXT;
          end
          S_NEXT:
          begin
            if (unit >= unit_limit)
              state <= S_END;
            else
            begin
              unit  <= unit + 7'h01;
              state <= S_POLL;
            end
          end
          S_END:
          begin
            state <= S_START;
            if (!dual)
            begin
              if (any_silent)
                dual <= 1'b1;                          // [R7]
              else
              begin
                // A clean one-ended round proves the loop whole again.
                cutoff   <= 1'b0;                      // [R10] [R12]
                shorted  <= 1'b0;
                reported <= 1'b0;
              end
            end
            else
            begin
              if (!reported)
              begin
                reported <= 1'b1;
                if (!any_silent)
                  cutoff <= 1'b1;                      // [R8]
              end
              if (retry_pend)
              begin
                dual       <= 1'b0;                    // [R10]
                retry_pend <= 1'b0;
              end
            end
          end
          S_OFF:
          begin
            drive_a <= 1'b0;
            drive_b <= 1'b0;
            if (retry_tick)
            begin
              dual  <= 1'b0;                           // [R12]
              state <= S_START;
            end
          end
          default:
            state <= S_START;
        endcase
      end
    end
  end

endmodule // dls_loop_ctrl

`default_nettype wire

// [dls_loop_units.sv]
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// Chain of loop units on four loops
// ---------------------------------------------------------------------------
module dls_loop_units
(
  input  wire logic        clk_sys,
  input  wire logic [3:0]  poll_req,
  input  wire logic [27:0] poll_unit,
  input  wire logic [3:0]  drive_a,
  input  wire logic [3:0]  drive_b,
  input  wire logic [27:0] brk_a,
  input  wire logic [27:0] brk_b,
  input  wire logic [3:0]  short_on,
  input  wire logic [3:0]  slow,
  output var  logic [3:0]  short_sense,
  output var  logic [3:0]  answer_ok,
  output var  logic [3:0]  answer_none
);
  logic [3:0] busy = 4'h0;
  logic [3:0] heard = 4'h0;
  logic [3:0] wait_cnt [4];
  int         g;

  assign short_sense = short_on;

  // Units below brk_a answer on end A, from brk_b up on end B, as driven
  // when the poll goes out. A short silences the loop it sits on.
  always @(posedge clk_sys)
  begin
    for (g = 0; g < 4; g++)
    begin
      answer_ok[g] <= 1'b0;
      answer_none[g] <= 1'b0;
      if (poll_req[g])
      begin
        busy[g] <= 1'b1;
        wait_cnt[g] <= slow[g] ? 4'h9 : 4'h0;
        heard[g] <= !short_on[g] &&
          ((drive_a[g] && poll_unit[g*7+:7] < brk_a[g*7+:7]) ||
           (drive_b[g] && poll_unit[g*7+:7] >= brk_b[g*7+:7]));
      end
      else if (busy[g] && wait_cnt[g] != 4'h0)
        wait_cnt[g] <= wait_cnt[g] - 4'h1;
      else if (busy[g])
      begin
        busy[g] <= 1'b0;
        answer_ok[g] <= heard[g];
        answer_none[g] <= !heard[g];
      end
    end
  end
endmodule // dls_loop_units
`default_nettype wire

// [dls_sup_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// Port checks of the loop supervisor
// ---------------------------------------------------------------------------
module dls_sup_assertions
(
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        addr_jumper_bit0,
  input wire logic        addr_jumper_bit1,
  input wire logic        addr_jumper_bit2,
  input wire logic [4:0]  panel_index,
  input wire logic [27:0] unit_count,
  input wire logic [3:0]  short_sense,
  input wire logic        fault_ack,
  input wire logic [3:0]  poll_req,
  input wire logic [27:0] poll_unit,
  input wire logic [3:0]  drive_a,
  input wire logic [3:0]  drive_b,
  input wire logic [3:0]  loop_dual,
  input wire logic [3:0]  loop_cutoff,
  input wire logic [3:0]  loop_shorted,
  input wire logic [2:0]  board_no,
  input wire logic        fault_valid,
  input wire logic [1:0]  fault_kind,
  input wire logic [1:0]  fault_loop,
  input wire logic [2:0]  fault_board,
  input wire logic [4:0]  fault_panel,
  input wire logic [6:0]  fault_unit
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Jumpers are synchronised, so they must settle for a few edges first.
  property p_board;
    (clk_en && $stable({addr_jumper_bit2, addr_jumper_bit1,
      addr_jumper_bit0}))[*4]
      |-> board_no == {1'b0, addr_jumper_bit1, addr_jumper_bit0};
  endproperty
  a_board: assert property (p_board) else $error("board number wrong");

  // Polled addresses stay within the configured count on loop 0 and within 1 to 99 on loop 3.
  property p_range;
    (!poll_req[3] || (poll_unit[27:21] inside {[7'h01:7'h63]})) &&
    (!poll_req[0] || (poll_unit[6:0] inside {[7'h01:unit_count[6:0]]}));
  endproperty
  a_range: assert property (p_range) else $error("unit out of range");

  // Loop 3 never breaks, so exactly one end is driven once running.
  property p_dir;
    (drive_a[3] | drive_b[3]) |-> (drive_a[3] ^ drive_b[3]);
  endproperty
  a_dir: assert property (p_dir) else $error("one-ended drive lost");

  // A cut-off is only concluded from a two-ended round.
  property p_cut;
    ((loop_cutoff & ~$past(loop_cutoff)) & ~$past(loop_dual)) == 4'h0;
  endproperty
  a_cut: assert property (p_cut) else $error("cutoff outside dual");

  property p_cut_fault;
    $rose(loop_cutoff[0]) |->
      ##[1:300] (fault_valid && fault_kind == 2'h1 && fault_loop == 2'h0);
  endproperty
  a_cut_fault: assert property (p_cut_fault) else $error("no cutoff word");

  property p_word;
    fault_valid |-> fault_board == board_no && fault_panel == panel_index;
  endproperty
  a_word: assert property (p_word) else $error("fault origin wrong");

  property p_nr;
    fault_valid && fault_kind == 2'h3
      |-> fault_unit != 7'h00 && loop_dual[fault_loop];
  endproperty
  a_nr: assert property (p_nr) else $error("no-reply word wrong");

  property p_short_stop;
    short_sense[2] [*5] |-> ##[0:2] loop_shorted[2];
  endproperty
  a_short_stop: assert property (p_short_stop) else $error("short ignored");

  property p_short_rise;
    ((loop_shorted & ~$past(loop_shorted)) & (drive_a | drive_b)) == 4'h0;
  endproperty
  a_short_rise: assert property (p_short_rise) else $error("still driven");

  property p_stop_poll;
    (poll_req & ~(drive_a | drive_b)) == 4'h0;
  endproperty
  a_stop_poll: assert property (p_stop_poll) else $error("poll undriven");

  property p_hold;
    fault_valid && !fault_ack |=> fault_valid && $stable(fault_kind) &&
      $stable(fault_loop) && $stable(fault_unit);
  endproperty
  a_hold: assert property (p_hold) else $error("fault word dropped");

  c_cut: cover property (fault_valid && fault_kind == 2'h1);
  c_short: cover property (fault_valid && fault_kind == 2'h2);
  c_nr: cover property (fault_valid && fault_kind == 2'h3);
endmodule // dls_sup_assertions

bind dls_supervisor dls_sup_assertions u_sup_chk (.*);
`default_nettype wire

// [dls_supervisor.v]
// How it works
// [R1] The board number is read from the jumpers as a binary value, a fitted jumper being one and the first jumper the low bit.
// [R2] On this board only the first two jumpers count and the third is ignored.
// [R3] Four loops, numbered 0 to 3, are each supervised by a controller of their own.
// [R4] Each loop polls unit addresses 1 up to the configured count, never above 99.
// [R5] Normal rounds drive one end of the loop and the driven end swaps every 60 seconds.
// [R6] A break next to the panel shows as silence after the next swap, so its fault follows within 60 to 100 seconds.
// [R7] A round with silent units switches the loop to polling from both ends.
// [R8] If every unit answers under two-ended polling, one cut-off fault names loop, board and panel.
// [R9] Each unit still silent under two-ended polling raises its own no-reply fault with its number.
// [R10] Every tenth minute a one-ended round is tried again, and a clean one restores normal polling.
// [R11] A short stops polling, releases both ends and raises a short-circuit fault naming loop, board and panel.
// [R12] A shorted loop is tried again every tenth minute and resumes once the short is gone.
// [R13] Isolators on the loop cut off only the shorted segment, so units beyond it keep answering; here a short stops polling of the whole loop.
// [R14] Silence past some point of a one-ended round means a break, and a raised fault is held until acknowledged.
`timescale 1ns/100ps
`default_nettype none

`include "dls_defines.vh"

module dls_supervisor
#(
  // Clock cycles in one second; shorten for simulation.
  parameter SEC_CYCLES = `DLS_CLK_MHZ * `DLS_US_PER_S
)
(
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        clk_en,
  input  wire        addr_jumper_bit0,
  input  wire        addr_jumper_bit1,
  input  wire        addr_jumper_bit2,
  input  wire [4:0]  panel_index,
  input  wire [27:0] unit_count,
  input  wire [3:0]  short_sense,
  input  wire [3:0]  answer_ok,
  input  wire [3:0]  answer_none,
  input  wire        fault_ack,
  output wire [3:0]  poll_req,
  output wire [27:0] poll_unit,
  output wire [3:0]  drive_a,
  output wire [3:0]  drive_b,
  output wire [3:0]  loop_dual,
  output wire [3:0]  loop_cutoff,
  output wire [3:0]  loop_shorted,
  output reg  [2:0]  board_no,
  output reg         fault_valid,
  output reg  [1:0]  fault_kind,
  output reg  [1:0]  fault_loop,
  output reg  [2:0]  fault_board,
  output reg  [4:0]  fault_panel,
  output reg  [6:0]  fault_unit
);

  localparam [31:0] SEC_LAST = SEC_CYCLES - 1;

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // Board number from the three jumpers, honouring the third-jumper option.
  function [2:0] dls_board;
    input j0;
    input j1;
    input j2;
    input use_j2;
    begin
      dls_board = 3'h0;
      dls_board[`DLS_JMP_BIT0] = j0;                   // [R1]
      dls_board[`DLS_JMP_BIT1] = j1;
      dls_board[`DLS_JMP_BIT2] = j2 & use_j2;          // [R2]
    end
  endfunction

  // Lowest set bit of a loop mask, used by every fault source.
  function [1:0] dls_first;
    input [3:0] mask;
    begin
      if (mask[0])
        dls_first = 2'h0;
      else if (mask[1])
        dls_first = 2'h1;
      else if (mask[2])
        dls_first = 2'h2;
      else
        dls_first = 2'h3;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg [2:0] jmp_meta;
  reg [2:0] jmp_sync;
  reg [3:0] short_meta;
  reg [3:0] short_sync;

  // Jumpers and short sensing are pins; each passes two flip-flops.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      jmp_meta   <= 3'h0;
      jmp_sync   <= 3'h0;
      short_meta <= 4'h0;
      short_sync <= 4'h0;
    end
    else if (clk_en)
    begin
      jmp_meta   <= {addr_jumper_bit2, addr_jumper_bit1, addr_jumper_bit0};
      jmp_sync   <= jmp_meta;
      short_meta <= short_sense;
      short_sync <= short_meta;
    end
  end

  // Board number is refreshed from the synchronised jumpers every cycle.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      board_no <= `DLS_BOARD_RST;
    else if (clk_en)
      board_no <= dls_board(jmp_sync[0], jmp_sync[1], jmp_sync[2],
                            `DLS_USE_JUMPER2);         // [R1] [R2]
  end

  // --------------------------------------------------------------------------
  // Time base
  // --------------------------------------------------------------------------
  reg [31:0] sec_cnt;
  reg        sec_tick;
  reg [9:0]  swap_sec;
  reg [9:0]  retry_sec;
  reg        dir_tick;
  reg        retry_tick;

  // One-second prescaler; all loops share the swap and retry ticks.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sec_cnt  <= 32'h0;
      sec_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      sec_tick <= (sec_cnt == SEC_LAST);
      if (sec_cnt == SEC_LAST)
        sec_cnt <= 32'h0;
      else
        sec_cnt <= sec_cnt + 32'h1;
    end
  end

  // The swap period bounds how late a break beside the panel is seen: the
  // next swap finds the near units silent, so a round must stay short.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      swap_sec   <= 10'h000;
      retry_sec  <= 10'h000;
      dir_tick   <= 1'b0;
      retry_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      dir_tick   <= 1'b0;
      retry_tick <= 1'b0;
      if (sec_tick)
      begin
        if (swap_sec == `DLS_DIR_SWAP_S - 10'h001)
        begin
          swap_sec <= 10'h000;
          dir_tick <= 1'b1;                            // [R5] [R6]
        end
        else
          swap_sec <= swap_sec + 10'h001;
        if (retry_sec == `DLS_RETRY_S - 10'h001)
        begin
          retry_sec  <= 10'h000;
          retry_tick <= 1'b1;                          // [R10] [R12]
        end
        else
          retry_sec <= retry_sec + 10'h001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Loop controllers
  // --------------------------------------------------------------------------
  wire [3:0]  nr_valid;
  wire [27:0] nr_unit;
  reg  [3:0]  nr_taken;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_loop
      wire [6:0] req_count;
      wire [6:0] limit;

      // Configured counts above the loop capacity are clamped.
      assign req_count = unit_count[g*7 +: 7];
      assign limit     = (req_count > `DLS_MAX_UNITS) ? `DLS_MAX_UNITS
                                                      : req_count; // [R4]

      // Each loop is supervised on its own.
      dls_loop_ctrl u_loop                             // [R3]
      (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .clk_en      (clk_en),
        .dir_tick    (dir_tick),
        .retry_tick  (retry_tick),
        .short_seen  (short_sync[g]),
        .unit_limit  (limit),
        .answer_ok   (answer_ok[g]),
        .answer_none (answer_none[g]),
        .nr_taken    (nr_taken[g]),
        .poll_req    (poll_req[g]),
        .poll_unit   (poll_unit[g*7 +: 7]),
        .drive_a     (drive_a[g]),
        .drive_b     (drive_b[g]),
        .dual        (loop_dual[g]),
        .cutoff      (loop_cutoff[g]),
        .shorted     (loop_shorted[g]),
        .nr_valid    (nr_valid[g]),
        .nr_unit     (nr_unit[g*7 +: 7])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Fault reporting
  // --------------------------------------------------------------------------
  reg  [3:0] cut_q;
  reg  [3:0] short_q;
  reg  [3:0] cut_pend;
  reg  [3:0] short_pend;
  reg  [3:0] cut_take;
  reg  [3:0] short_take;
  reg  [1:0] pick;
  reg        load;
  reg  [1:0] next_kind;
  reg  [6:0] next_unit;
  wire [3:0] cut_rise;
  wire [3:0] short_rise;
  wire       port_free;

  assign cut_rise   = loop_cutoff & ~cut_q;
  assign short_rise = loop_shorted & ~short_q;
  // The port takes a new fault once the held one has been acknowledged.
  assign port_free  = ~fault_valid | fault_ack;

  // Shorts go first, then cut-offs, then single silent units.
  always @*
  begin
    pick       = 2'h0;
    load       = 1'b0;
    next_kind  = `DLS_FK_NONE;
    next_unit  = 7'h00;
    cut_take   = 4'h0;
    short_take = 4'h0;
    nr_taken   = 4'h0;
    if (port_free)
    begin
      if (short_pend != 4'h0)
      begin
        pick       = dls_first(short_pend);
        load       = 1'b1;
        next_kind  = `DLS_FK_SHORT;                    // [R11]
        short_take[pick] = 1'b1;
      end
      else if (cut_pend != 4'h0)
      begin
        pick      = dls_first(cut_pend);
        load      = 1'b1;
        next_kind = `DLS_FK_CUTOFF;                    // [R8]
        cut_take[pick] = 1'b1;
      end
      else if (nr_valid != 4'h0)
      begin
        pick      = dls_first(nr_valid);
        load      = 1'b1;
        next_kind = `DLS_FK_NOREPLY;                   // [R9]
        next_unit = nr_unit[pick*7 +: 7];
        nr_taken[pick] = 1'b1;
      end
    end
  end

  // A new cut-off or short arriving as its pending bit is taken stays set.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cut_q      <= 4'h0;
      short_q    <= 4'h0;
      cut_pend   <= 4'h0;
      short_pend <= 4'h0;
    end
    else if (clk_en)
    begin
      cut_q      <= loop_cutoff;
      short_q    <= loop_shorted;
      cut_pend   <= (cut_pend & ~cut_take) | cut_rise;
      short_pend <= (short_pend & ~short_take) | short_rise;
    end
  end

  // The fault word is held until the operator side acknowledges it.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fault_valid <= 1'b0;
      fault_kind  <= `DLS_FK_NONE;
      fault_loop  <= 2'h0;
      fault_board <= `DLS_BOARD_RST;
      fault_panel <= 5'h00;
      fault_unit  <= 7'h00;
    end
    else if (clk_en)
    begin
      if (load)
      begin
        fault_valid <= 1'b1;                           // [R14]
        fault_kind  <= next_kind;
        fault_loop  <= pick;
        fault_board <= board_no;
        fault_panel <= panel_index;
        fault_unit  <= next_unit;
      end
      else if (fault_ack)
        fault_valid <= 1'b0;
    end
  end

endmodule // dls_supervisor

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// Supervisor bench
// ---------------------------------------------------------------------------
module tb_top;
  localparam int SEC = 16;
  logic        clk_sys;
  logic        reset_n;
  logic        clk_en;
  logic [2:0]  jmp;
  logic [4:0]  panel_index;
  logic [27:0] unit_count;
  logic        fault_ack;
  logic [27:0] brk_a;
  logic [27:0] brk_b;
  logic [3:0]  short_on;
  logic [3:0]  slow;
  wire  [3:0]  short_sense, answer_ok, answer_none, poll_req, drive_a;
  wire  [3:0]  drive_b, loop_dual, loop_cutoff, loop_shorted;
  wire  [27:0] poll_unit;
  wire  [2:0]  board_no, fault_board;
  wire         fault_valid;
  wire  [1:0]  fault_kind, fault_loop;
  wire  [4:0]  fault_panel;
  wire  [6:0]  fault_unit;
  int          error_cnt;
  int          samples_checked;

  dls_supervisor #(.SEC_CYCLES(SEC)) dut
  (
    .addr_jumper_bit0(jmp[0]), .addr_jumper_bit1(jmp[1]),
    .addr_jumper_bit2(jmp[2]), .*
  );

  dls_loop_units u_units (.*);

  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Waits for a fault word, judges it and acknowledges it with one pulse.
  task automatic take_fault(input logic [1:0] kind, input logic [1:0] lp,
                            input logic [6:0] unit, output int n);
    n = 0;
    while (fault_valid !== 1'b1)
    begin
      @(posedge clk_sys);
      n++;
      if (n > 4000)
      begin
        error_cnt++;
        close_out;
      end
    end
    check({fault_kind, fault_loop, fault_unit}, {kind, lp, unit});
    check({fault_board, fault_panel}, {3'h1, 5'h13});
    fault_ack <= 1'b1;
    @(posedge clk_sys);
    fault_ack <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Retries come only every ten minutes, so the bound must cover one.
  task automatic wait_calm;
    int n;
    n = 0;
    while ((loop_dual | loop_cutoff | loop_shorted) !== 4'h0)
    begin
      @(posedge clk_sys);
      n++;
      if (n > 700 * SEC)
      begin
        error_cnt++;
        close_out;
      end
    end
    // One more edge lets a resumed round set its drive.
    @(posedge clk_sys);
  endtask

  task automatic t_board;
    int v;
    for (v = 0; v < 8; v++)
    begin
      jmp <= v[2:0];
      repeat (6) @(posedge clk_sys);
      check(board_no, {1'b0, v[1:0]});
      check(board_no[2], 1'b0);
    end
    jmp <= 3'h5;
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic t_swap;
    logic       a0;
    int         n;
    int         last;
    logic [6:0] top;
    top = 7'h00;
    last = 0;
    a0 = drive_a[3];
    for (n = 1; n <= 3000; n++)
    begin
      @(posedge clk_sys);
      if (poll_req[3] === 1'b1 && poll_unit[27:21] > top)
        top = poll_unit[27:21];
      if (drive_a[3] !== a0)
      begin
        if (last != 0)
          check((n - last) inside {[400:1600]}, 1'b1);
        check(drive_b[3] ^ drive_a[3], 1'b1);
        last = n;
        a0 = drive_a[3];
      end
    end
    check(top, 7'h63);
    check(last > 0, 1'b1);
  endtask

  task automatic t_far;
    int n;
    brk_b[6:0] <= 7'h05;
    take_fault(2'h1, 2'h0, 7'h00, n);
    check(n <= 100 * SEC, 1'b1);
    check(loop_dual[0], 1'b1);
    brk_b[6:0] <= 7'h00;
  endtask

  task automatic t_double;
    int n;
    brk_a[13:7] <= 7'h02;
    brk_b[13:7] <= 7'h04;
    take_fault(2'h3, 2'h1, 7'h02, n);
    take_fault(2'h3, 2'h1, 7'h03, n);
    repeat (60) @(posedge clk_sys);
    check(loop_cutoff[1], 1'b0);
    check(loop_dual[3], 1'b0);
    brk_a[13:7] <= 7'h7f;
    brk_b[13:7] <= 7'h00;
    wait_calm;
    check(loop_cutoff, 4'h0);
    check(drive_a[1] ^ drive_b[1], 1'b1);
  endtask

  task automatic t_short;
    int n;
    short_on[2] <= 1'b1;
    take_fault(2'h2, 2'h2, 7'h00, n);
    check(drive_a[2] | drive_b[2], 1'b0);
    check(loop_shorted[2], 1'b1);
    short_on[2] <= 1'b0;
    wait_calm;
    check(loop_shorted, 4'h0);
    check(drive_a[2] ^ drive_b[2], 1'b1);
  endtask

  // Reset, then the scenarios in an order that leaves each loop intact.
  initial
  begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    jmp = 3'h0;
    panel_index = 5'h13;
    unit_count = {7'h7f, 7'h03, 7'h05, 7'h04};
    brk_a = {4{7'h7f}};
    brk_b = 28'h0;
    short_on = 4'h0;
    slow = 4'h2;
    fault_ack = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_board;
    t_swap;
    t_far;
    t_double;
    t_short;
    close_out;
  end
endmodule // tb_top
`default_nettype wire
